/* rtl/trs_pkg.sv */
// package of constants, register map and carrier types for the tone pair receiver steering
package trs_pkg;

    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS   = 100;
    // guard counters advance in ticks of this length
    localparam int unsigned GUARD_TICK_NS   = 100000;
    localparam int unsigned GUARD_TICK_CYC  = GUARD_TICK_NS / CLK_PERIOD_NS;
    // settling time between registration and the latch update, which comes with the delayed steering flag
    localparam int unsigned SETTLE_NS       = 200;
    localparam int unsigned SETTLE_CYC      =
        (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned CODE_W = 4;

    localparam logic [ADDR_W-1:0] RX_DATA_OFS = 4'h0;
    localparam logic [ADDR_W-1:0] TX_DATA_OFS = 4'h1;
    localparam logic [ADDR_W-1:0] STATUS_OFS  = 4'h2;
    localparam logic [ADDR_W-1:0] CTRL_A_OFS  = 4'h3;
    localparam logic [ADDR_W-1:0] CTRL_B_OFS  = 4'h4;
    localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 4'h5;
    localparam logic [ADDR_W-1:0] GTP_OFS     = 4'h6;
    localparam logic [ADDR_W-1:0] GTA_OFS     = 4'h7;

    // status register bit positions
    localparam int unsigned ST_DIGIT_BIT   = 0;
    localparam int unsigned ST_PAUSE_BIT   = 1;
    localparam int unsigned ST_DSTEER_BIT  = 2;
    localparam int unsigned ST_ESTEER_BIT  = 3;
    localparam int unsigned ST_GUARD_BIT   = 4;
    localparam int unsigned EVT_W          = 2;

    // control register A bit positions
    localparam int unsigned CA_IRQ_EN_BIT  = 0;
    localparam int unsigned CA_CP_MODE_BIT = 1;

    // reset values
    localparam logic [DATA_W-1:0] GTP_RST     = 8'h14;
    localparam logic [DATA_W-1:0] GTA_RST     = 8'h14;
    localparam logic [CODE_W-1:0] CODE_RST    = 4'h0;
    localparam logic [CODE_W-1:0] CTRL_B_RST  = 4'h0;
    localparam logic [EVT_W-1:0]  MASK_RST    = 2'h0;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } trs_bus_req_s;

    typedef struct packed {
        logic cp_mode;
        logic irq_en;
    } trs_ctrl_a_s;

    typedef struct packed {
        logic       guard;
        logic       esteer;
        logic       dsteer;
        logic [EVT_W-1:0] events;
    } trs_status_s;

endpackage

/* rtl/trs_guard_ctr.sv */
// guard timer: reports once a condition has held for a programmed number of ticks
`timescale 1ns/1ns
`default_nettype none
module trs_guard_ctr
    import trs_pkg::*;
(
    input  wire logic              sys_clk_i,
    input  wire logic              nrst_i,
    input  wire logic              cond_i,
    input  wire logic              tick_i,
    input  wire logic [DATA_W-1:0] limit_i,
    output var  logic              done_o
);
    logic [DATA_W-1:0] cnt;

    // ------------------------------------------------------------------
    // tick counter, restarted whenever the condition drops
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i || !cond_i) begin
            cnt <= '0;
        end else if (tick_i && cnt < limit_i) begin
            cnt <= cnt + 8'h01;
        end
    end

    // done only while the condition still holds, so a break restarts it
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            done_o <= 1'b0;
        end else begin
            done_o <= cond_i && (cnt >= limit_i);
        end
    end
endmodule // trs_guard_ctr
`default_nettype wire

/* rtl/trs_steering.sv */
// receive steering, digit latch, call progress output and host registers
// ----------------------------------------------------------------------
// Functional notes
// - early steer goes high when the decoder reports two valid tones
// - early steer drops at once whenever the tone pair is lost
// - register a pair only after early steer holds for the present guard
// - registration latches the 4-bit digit code into receive data
// - guard output rises on registration and holds while early steer is high
// - delayed steer flag sets after a settle delay, visible in status
// - in interrupt mode the pin is pulled low while delayed steer is set
// - receive latch changes only on a rising delayed steer transition
// - reading receive data returns the latched digit code
// - dropouts shorter than the absent guard leave the registered state alone
// - call-progress mode disables digit detection
// - call-progress mode squares in-band input onto the pin, low otherwise
// - host sees one status, two control and two data registers; the code adds an interrupt mask and two guard limit registers
// - squarewave appears only with call-progress mode and interrupts enabled
// - steering below threshold frees the receiver for a new pair
// ----------------------------------------------------------------------
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module trs_steering
    import trs_pkg::*;
(
    input  wire logic              sys_clk_i,
    input  wire logic              nrst_i,
    // decoder side, asynchronous to sys_clk_i
    input  wire logic              tone_pair_valid_i,
    input  wire logic [CODE_W-1:0] tone_code_i,
    input  wire logic              inband_sq_i,
    // register port
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output var  logic [DATA_W-1:0] rdata_o,
    // pins
    output var  logic              early_steer_o,
    output var  logic              guard_out_o,
    output var  logic              irq_callprog_pin_o,
    output var  logic              irq_callprog_pin_oe_o,
    output var  logic              irq_o
);
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SETTLE,
        ST_HELD
    } trs_steer_e;

    trs_bus_req_s      req;
    trs_ctrl_a_s       ctrl_a;
    trs_status_s       status;
    trs_steer_e        state;
    logic [1:0]        valid_sync;
    logic [1:0]        sq_sync;
    logic [CODE_W-1:0] code_s1;
    logic [CODE_W-1:0] code_s2;
    logic [CODE_W-1:0] pend_code;
    logic [CODE_W-1:0] rx_code;
    logic [CODE_W-1:0] tx_code;
    logic [CODE_W-1:0] ctrl_b;
    logic [DATA_W-1:0] gtp_limit;
    logic [DATA_W-1:0] gta_limit;
    logic [EVT_W-1:0]  evt_flags;
    logic [EVT_W-1:0]  evt_mask;
    logic [EVT_W-1:0]  evt_set;
    logic [EVT_W-1:0]  evt_clr;
    logic [15:0]       tick_cnt;
    logic              tick;
    logic [3:0]        settle_cnt;
    logic              dsteer;
    logic              registered;
    logic              present_done;
    logic              absent_done;
    logic              next_esteer;

    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    // the code is resampled every cycle and taken only at registration,
    // so a skewed bus has settled long before it is used
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            valid_sync <= 2'h0;
            sq_sync    <= 2'h0;
            code_s1    <= CODE_RST;
            code_s2    <= CODE_RST;
        end else begin
            valid_sync <= {valid_sync[0], tone_pair_valid_i};
            sq_sync    <= {sq_sync[0], inband_sq_i};
            code_s1    <= tone_code_i;
            code_s2    <= code_s1;
        end
    end

    // ------------------------------------------------------------------
    // early steering
    // ------------------------------------------------------------------
    // digits are not detected at all in call-progress mode
    assign next_esteer = valid_sync[1] && !ctrl_a.cp_mode;

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            early_steer_o <= 1'b0;
        end else begin
            early_steer_o <= next_esteer;
        end
    end

    // ------------------------------------------------------------------
    // guard timers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i || tick_cnt == 16'(GUARD_TICK_CYC - 1)) begin
            tick_cnt <= 16'h0000;
        end else begin
            tick_cnt <= tick_cnt + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            tick <= 1'b0;
        end else begin
            tick <= (tick_cnt == 16'(GUARD_TICK_CYC - 1));
        end
    end

    // tone present must be seen continuously for gtp_limit ticks
    trs_guard_ctr u_present (
        .sys_clk_i (sys_clk_i),
        .nrst_i    (nrst_i),
        .cond_i    (early_steer_o && !registered),
        .tick_i    (tick),
        .limit_i   (gtp_limit),
        .done_o    (present_done)
    );

    // tone absent must be seen continuously for gta_limit ticks
    trs_guard_ctr u_absent (
        .sys_clk_i (sys_clk_i),
        .nrst_i    (nrst_i),
        .cond_i    (!early_steer_o && registered),
        .tick_i    (tick),
        .limit_i   (gta_limit),
        .done_o    (absent_done)
    );

    // ------------------------------------------------------------------
    // steering state
    // ------------------------------------------------------------------
    assign registered = (state != ST_IDLE);

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (present_done && early_steer_o) begin
                        state <= ST_SETTLE;
                    end
                end
                ST_SETTLE: begin
                    if (settle_cnt == 4'(SETTLE_CYC - 1)) begin
                        state <= ST_HELD;
                    end
                end
                ST_HELD: begin
                    // a short dropout never reaches the absent guard
                    if (absent_done) begin
                        state <= ST_IDLE;
                    end
                end
                // the fourth code of the state bits is unused; recover to idle
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // settle counter runs only while the latch settles
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i || state != ST_SETTLE) begin
            settle_cnt <= 4'h0;
        end else begin
            settle_cnt <= settle_cnt + 4'h1;
        end
    end

    // code captured at registration, copied to the latch once settled
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            pend_code <= CODE_RST;
        end else if (state == ST_IDLE && present_done && early_steer_o) begin
            pend_code <= code_s2;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            dsteer <= 1'b0;
        end else begin
            dsteer <= (state == ST_HELD);
        end
    end

    // the latch moves only on the rising delayed steer edge
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            rx_code <= CODE_RST;
        end else if (state == ST_HELD && !dsteer) begin
            rx_code <= pend_code;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            guard_out_o <= 1'b0;
        end else begin
            guard_out_o <= registered && next_esteer;
        end
    end

    // ------------------------------------------------------------------
    // interrupt and call-progress pin
    // ------------------------------------------------------------------
    // open drain: driving means pulling low, release lets it float high
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            irq_callprog_pin_o    <= 1'b0;
            irq_callprog_pin_oe_o <= 1'b0;
        end else if (ctrl_a.cp_mode && ctrl_a.irq_en) begin
            irq_callprog_pin_o    <= 1'b0;
            irq_callprog_pin_oe_o <= !sq_sync[1];
        end else if (ctrl_a.irq_en) begin
            irq_callprog_pin_o    <= 1'b0;
            irq_callprog_pin_oe_o <= dsteer;
        end else begin
            irq_callprog_pin_o    <= 1'b0;
            irq_callprog_pin_oe_o <= 1'b0;
        end
    end

    // events: new digit and a validated end of tone
    assign evt_set = {(state == ST_HELD && absent_done),
                      (state == ST_HELD && !dsteer)};
    assign evt_clr = (req.wr && req.addr == STATUS_OFS) ?
                     req.wdata[EVT_W-1:0] : '0;

    // a new event wins over a clear in the same cycle
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            evt_flags <= '0;
        end else begin
            evt_flags <= (evt_flags & ~evt_clr) | evt_set;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(((evt_flags & ~evt_clr) | evt_set) & evt_mask);
        end
    end

    // ------------------------------------------------------------------
    // register writes, one block per register
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            tx_code <= CODE_RST;
        end else if (req.wr && req.addr == TX_DATA_OFS) begin
            tx_code <= req.wdata[CODE_W-1:0];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            ctrl_a <= '0;
        end else if (req.wr && req.addr == CTRL_A_OFS) begin
            ctrl_a.irq_en  <= req.wdata[CA_IRQ_EN_BIT];
            ctrl_a.cp_mode <= req.wdata[CA_CP_MODE_BIT];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            ctrl_b <= CTRL_B_RST;
        end else if (req.wr && req.addr == CTRL_B_OFS) begin
            ctrl_b <= req.wdata[CODE_W-1:0];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            evt_mask <= MASK_RST;
        end else if (req.wr && req.addr == IRQ_MASK_OFS) begin
            evt_mask <= req.wdata[EVT_W-1:0];
        end
    end

    // a new limit acts at once, even inside a running guard period
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            gtp_limit <= GTP_RST;
        end else if (req.wr && req.addr == GTP_OFS) begin
            gtp_limit <= req.wdata;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            gta_limit <= GTA_RST;
        end else if (req.wr && req.addr == GTA_OFS) begin
            gta_limit <= req.wdata;
        end
    end

    // ------------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------------
    assign status = '{guard: guard_out_o, esteer: early_steer_o,
                      dsteer: dsteer, events: evt_flags};

    // data appear the cycle after the read strobe; unmapped reads return zero
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            rdata_o <= '0;
        end else if (req.rd) begin
            unique case (req.addr)
                RX_DATA_OFS:  rdata_o <= {4'h0, rx_code};
                TX_DATA_OFS:  rdata_o <= {4'h0, tx_code};
                STATUS_OFS:   rdata_o <= {3'h0, status};
                CTRL_A_OFS:   rdata_o <= {6'h00, ctrl_a};
                CTRL_B_OFS:   rdata_o <= {4'h0, ctrl_b};
                IRQ_MASK_OFS: rdata_o <= {6'h00, evt_mask};
                GTP_OFS:      rdata_o <= gtp_limit;
                GTA_OFS:      rdata_o <= gta_limit;
                default:      rdata_o <= '0;
            endcase
        end else begin
            rdata_o <= '0;
        end
    end
endmodule // trs_steering
`default_nettype wire

/* testbench/trs_steering_monitor.sv */
// port checker for the receive steering block
`timescale 1ns/1ns
`default_nettype none
module trs_steering_monitor
    import trs_pkg::*;
(
    input wire logic              sys_clk_i,
    input wire logic              nrst_i,
    input wire logic              tone_pair_valid_i,
    input wire logic [CODE_W-1:0] tone_code_i,
    input wire logic              inband_sq_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic              wr_i,
    input wire logic              rd_i,
    input wire logic [DATA_W-1:0] rdata_o,
    input wire logic              early_steer_o,
    input wire logic              guard_out_o,
    input wire logic              irq_callprog_pin_o,
    input wire logic              irq_callprog_pin_oe_o,
    input wire logic              irq_o
);
    // ----------------
    // control shadow
    // ----------------
    logic       cp_q;
    logic       en_q;
    logic       sq_prev;
    logic [2:0] sq_run;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            cp_q <= 1'b0;
            en_q <= 1'b0;
        end else if (wr_i && addr_i == CTRL_A_OFS) begin
            cp_q <= wdata_i[CA_CP_MODE_BIT];
            en_q <= wdata_i[CA_IRQ_EN_BIT];
        end
    end

    // squarewave judged only once input and mode outlived the syncs
    always_ff @(posedge sys_clk_i) begin
        sq_prev <= inband_sq_i;
        if (!nrst_i || !(cp_q && en_q) || inband_sq_i != sq_prev) begin
            sq_run <= 3'h0;
        end else if (sq_run != 3'h7) begin
            sq_run <= sq_run + 3'h1;
        end
    end

    property p_est_rise; (tone_pair_valid_i && !cp_q)[*4] |-> early_steer_o; endproperty
    a_est_rise: assert property (p_est_rise)
        else $error("early steer missing");
    property p_est_fall; (!tone_pair_valid_i)[*4] |-> !early_steer_o; endproperty
    a_est_fall: assert property (p_est_fall)
        else $error("early steer stuck");
    property p_est_cp; cp_q[*4] |-> !early_steer_o; endproperty
    a_est_cp: assert property (p_est_cp)
        else $error("digit detect in cp mode");
    property p_guard; guard_out_o |-> early_steer_o || $past(early_steer_o); endproperty
    a_guard: assert property (p_guard)
        else $error("guard without early steer");
    property p_rd_unmap; rd_i && addr_i > 4'h7 |=> rdata_o == 8'h00; endproperty
    a_rd_unmap: assert property (p_rd_unmap)
        else $error("unmapped read not zero");
    property p_rd_ctrl; rd_i && addr_i == CTRL_A_OFS |=> rdata_o == {6'h00, cp_q, en_q}; endproperty
    a_rd_ctrl: assert property (p_rd_ctrl)
        else $error("control read wrong");
    property p_cp_sq; sq_run >= 3'h3 |-> irq_callprog_pin_oe_o == !sq_prev; endproperty
    a_cp_sq: assert property (p_cp_sq)
        else $error("squarewave wrong");
    property p_pin_off; (!en_q)[*3] |-> !irq_callprog_pin_oe_o; endproperty
    a_pin_off: assert property (p_pin_off)
        else $error("pin pulled with irq off");
    property p_rd_idle; !rd_i |=> rdata_o == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside a read");
    property p_pin_lo; !irq_callprog_pin_o; endproperty
    a_pin_lo: assert property (p_pin_lo)
        else $error("pin driven high");

    c_reg: cover property ($rose(guard_out_o));
    c_sq: cover property (sq_run == 3'h3 && !irq_callprog_pin_oe_o);
    c_irq: cover property ($rose(irq_o));
endmodule // trs_steering_monitor
`default_nettype wire

/* testbench/trs_tone_src.sv */
// decoder stand-in presenting tone pairs and the in-band squarewave
`timescale 1ns/1ns
`default_nettype none
module trs_tone_src
    import trs_pkg::*;
(
    input  wire logic              sys_clk_i,
    output var  logic              valid_o,
    output var  logic [CODE_W-1:0] code_o,
    output var  logic              sq_o
);
    // ----------------
    // drive tasks
    // ----------------
    initial begin
        valid_o = 1'b0;
        code_o  = 4'h0;
        sq_o    = 1'b0;
    end

    // code stands while valid; when idle the lines show the inverse, not stale data
    task automatic hold(input logic v, input logic [CODE_W-1:0] c, input int n);
        @(posedge sys_clk_i);
        valid_o <= v;
        code_o  <= v ? c : ~c;
        repeat (n) @(posedge sys_clk_i);
    endtask

    task automatic square(input logic s, input int n);
        @(posedge sys_clk_i);
        sq_o <= s;
        repeat (n) @(posedge sys_clk_i);
    endtask
endmodule // trs_tone_src
`default_nettype wire

/* testbench/trs_steering_tb.sv */
// self-checking bench for the receive steering block
`timescale 1ns/1ns
`default_nettype none
module trs_steering_tb;
    import trs_pkg::*;
    logic              sys_clk_i = 1'b0;
    logic              nrst_i = 1'b0;
    logic              tone_pair_valid_i;
    logic [CODE_W-1:0] tone_code_i;
    logic              inband_sq_i;
    logic [ADDR_W-1:0] addr_i = 4'h0;
    logic [DATA_W-1:0] wdata_i = 8'h00;
    logic              wr_i = 1'b0;
    logic              rd_i = 1'b0;
    logic [DATA_W-1:0] rdata_o;
    logic              early_steer_o;
    logic              guard_out_o;
    logic              irq_callprog_pin_o;
    logic              irq_callprog_pin_oe_o;
    logic              irq_o;
    logic              rd_q = 1'b0;
    logic [15:0]       note_q[$];
    logic [15:0]       note;
    logic [7:0]        rnd;
    logic [CODE_W-1:0] code;
    int                n_fail = 0;
    int                cmp_count = 0;
    integer            seed = 32'h4fbb;

    always #50 sys_clk_i = ~sys_clk_i;

    trs_tone_src i_src (
        .sys_clk_i, .valid_o(tone_pair_valid_i), .code_o(tone_code_i), .sq_o(inband_sq_i)
    );
    trs_steering i_dut (
        .sys_clk_i, .nrst_i, .tone_pair_valid_i, .tone_code_i, .inband_sq_i, .addr_i,
        .wdata_i, .wr_i, .rd_i, .rdata_o, .early_steer_o, .guard_out_o,
        .irq_callprog_pin_o, .irq_callprog_pin_oe_o, .irq_o
    );

    // ----------------
    // checking
    // ----------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // read data stand only in the cycle after the strobe, so compare there
    always @(posedge sys_clk_i) begin
        rd_q <= rd_i;
        if (rd_q && note_q.size() > 0) begin
            note = note_q.pop_front();
            chk(rdata_o & note[15:8], note[7:0]);
        end
    end

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge sys_clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge sys_clk_i);
        wr_i    <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] m, input logic [7:0] e);
        note_q.push_back({m, e});
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge sys_clk_i);
        rd_i   <= 1'b0;
    endtask

    task automatic wait_on(input bit pin, input logic lvl, input int n);
        int i;
        for (i = 0; i < n; i++) begin
            @(posedge sys_clk_i);
            if ((pin ? irq_callprog_pin_oe_o : guard_out_o) === lvl) break;
        end
        if (i == n) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, !lvl, lvl);
            print_verdict();
        end
    endtask

    // registered outputs lag a write by two edges; sample mid-cycle
    task automatic out_chk(input bit sel, input logic e);
        repeat (2) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        chk({7'h00, sel ? irq_o : irq_callprog_pin_oe_o}, {7'h00, e});
    endtask

    initial begin
        repeat (20) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        rd(GTP_OFS, 8'hff, GTP_RST);
        rd(GTA_OFS, 8'hff, GTA_RST);
        rd(CTRL_B_OFS, 8'hff, 8'h00);
        rd(RX_DATA_OFS, 8'hff, 8'h00);
        rd(4'hf, 8'hff, 8'h00);
        rnd = 8'($random(seed));
        wr(TX_DATA_OFS, rnd);
        rd(TX_DATA_OFS, 8'hff, rnd & 8'h0f);
        // two ticks: a burst under one tick period can never qualify
        wr(GTP_OFS, 8'h02);
        wr(GTA_OFS, 8'h02);
        rd(GTP_OFS, 8'hff, 8'h02);
        wr(IRQ_MASK_OFS, 8'h03);
        wr(CTRL_A_OFS, 8'h01);
        rd(CTRL_A_OFS, 8'hff, 8'h01);
        i_src.hold(1'b1, 4'h5, 900);
        i_src.hold(1'b0, 4'h5, 2500);
        rd(STATUS_OFS, 8'h07, 8'h00);
        rd(RX_DATA_OFS, 8'hff, 8'h00);
        for (int k = 0; k < 3; k++) begin
            code = (k == 0) ? 4'h0 : 4'($random(seed));
            i_src.hold(1'b1, code, 0);
            wait_on(1'b0, 1'b1, 3000);
            wait_on(1'b1, 1'b1, 10);
            rd(RX_DATA_OFS, 8'hff, {4'h0, code});
            rd(STATUS_OFS, 8'h1f, 8'h1d);
            i_src.hold(1'b0, code, 300);
            i_src.hold(1'b1, code, 20);
            rd(STATUS_OFS, 8'h06, 8'h04);
            i_src.hold(1'b0, code, 0);
            wait_on(1'b1, 1'b0, 3000);
            rd(STATUS_OFS, 8'h07, 8'h03);
            rd(RX_DATA_OFS, 8'hff, {4'h0, code});
            wr(IRQ_MASK_OFS, 8'h00);
            out_chk(1'b1, 1'b0);
            wr(IRQ_MASK_OFS, 8'h03);
            out_chk(1'b1, 1'b1);
            wr(STATUS_OFS, 8'h03);
            out_chk(1'b1, 1'b0);
        end
        wr(CTRL_A_OFS, 8'h03);
        for (int k = 0; k < 4; k++) begin
            i_src.square(k[0], 10);
            out_chk(1'b0, !k[0]);
        end
        i_src.hold(1'b1, 4'h9, 3000);
        rd(STATUS_OFS, 8'h0d, 8'h00);
        i_src.hold(1'b0, 4'h9, 10);
        wr(CTRL_A_OFS, 8'h02);
        i_src.square(1'b0, 10);
        out_chk(1'b0, 1'b0);
        repeat (3) @(posedge sys_clk_i);
        print_verdict();
    end
endmodule // trs_steering_tb

bind trs_steering trs_steering_monitor i_mon (
    .sys_clk_i, .nrst_i, .tone_pair_valid_i, .tone_code_i, .inband_sq_i, .addr_i,
    .wdata_i, .wr_i, .rd_i, .rdata_o, .early_steer_o, .guard_out_o,
    .irq_callprog_pin_o, .irq_callprog_pin_oe_o, .irq_o
);
`default_nettype wire
